// *** ssc_pkg.sv ***
// Purpose: shared types and constants of the dual-channel safety controller
// Assumes: 100 MHz core clock, pins sampled through the three-stage filter
// Notes:   times are kept in microseconds, cycle counts derived from them
`default_nettype none

package ssc_pkg;

  // ---------------------------------------------------------------
  // clock and timing
  // ---------------------------------------------------------------
  localparam int unsigned CLK_MHZ         = 100;
  localparam int unsigned DISC_TIME_US    = 100000;
  localparam int unsigned DROP_TIME_US    = 50000;
  localparam int unsigned PICKUP_TIME_US  = 50000;
  localparam int unsigned DISC_CYCLES     = DISC_TIME_US * CLK_MHZ;
  localparam int unsigned DROP_CYCLES     = DROP_TIME_US * CLK_MHZ;
  localparam int unsigned PICKUP_CYCLES   = PICKUP_TIME_US * CLK_MHZ;
  localparam int unsigned TIMER_W         = 24;

  // ---------------------------------------------------------------
  // pin bundles
  // ---------------------------------------------------------------
  localparam int unsigned PIN_W = 6;

  typedef struct packed {
    logic safety_output_one;   // high = channel on
    logic safety_output_two;   // high = channel on
    logic reset_button;        // high = pressed
    logic first_contactor;     // aux contact, high = de-energized
    logic second_contactor;    // aux contact, high = de-energized
    logic mode_select;         // operating-mode selector level
  } ssc_pins_s;

  typedef struct packed {
    logic drive_first;         // energize first contactor
    logic drive_second;        // energize second contactor
    logic safe_state;          // machine held safe
    logic interlock_armed;     // waiting for a reset press
    logic discrepancy;         // channels differ beyond tolerance
    logic contactor_fault;     // contactor failed to follow
    logic locked;              // latched locking state
  } ssc_ctl_s;

  localparam ssc_ctl_s CTL_RESET = '{drive_first: 1'b0, drive_second: 1'b0, safe_state: 1'b1,
                                     interlock_armed: 1'b1, discrepancy: 1'b0,
                                     contactor_fault: 1'b0, locked: 1'b0};

  // ---------------------------------------------------------------
  // controller states
  // ---------------------------------------------------------------
  typedef enum logic [1:0] {
    ST_ARMED,
    ST_RUN,
    ST_DROP,
    ST_LOCK
  } ssc_state_e;

  typedef struct packed {
    ssc_state_e state;
    logic       btn_prev;
    logic       mode_prev;
    ssc_ctl_s   ctl;
  } ssc_main_s;

endpackage : ssc_pkg

`default_nettype wire

// *** ssc_sync.sv ***
// Purpose: three-stage pin synchroniser with agreement filter
// Assumes: inputs asynchronous to core_clk
// Notes:   output follows only when stages two and three agree
`default_nettype none
`timescale 1ns/1ps

module ssc_sync #(
  parameter int unsigned W = 1
) (
  // clock and reset
  input  wire logic         core_clk,
  input  wire logic         rst,
  // pins
  input  wire logic [W-1:0] pin_in,
  output logic      [W-1:0] pin_out
);

  typedef struct packed {
    logic [W-1:0] ff_a;
    logic [W-1:0] ff_b;
    logic [W-1:0] ff_c;
    logic [W-1:0] filt;
  } ssc_sync_s;

  ssc_sync_s q;
  ssc_sync_s d;

  always_comb begin
    d      = q;
    d.ff_a = pin_in;
    d.ff_b = q.ff_a;
    d.ff_c = q.ff_b;
    for (int i = 0; i < W; i++) begin
      if (q.ff_b[i] == q.ff_c[i]) begin
        d.filt[i] = q.ff_c[i];
      end
    end
  end

  always_ff @(posedge core_clk) begin
    if (rst) begin
      q <= '0;
    end else begin
      q <= d;
    end
  end

  assign pin_out = q.filt;

endmodule : ssc_sync

`default_nettype wire

// *** ssc_timer.sv ***
// Purpose: run-while-high timer with a sticky done level
// Assumes: limit fits in W bits
// Notes:   dropping run clears count and done
`default_nettype none
`timescale 1ns/1ps

module ssc_timer #(
  parameter int unsigned W     = 24,
  parameter int unsigned LIMIT = 1
) (
  // clock and reset
  input  wire logic core_clk,
  input  wire logic rst,
  // control
  input  wire logic run,
  output logic      done
);

  typedef struct packed {
    logic [W-1:0] cnt;
    logic         done;
  } ssc_timer_s;

  localparam logic [W-1:0] LIM = W'(LIMIT);

  ssc_timer_s q;
  ssc_timer_s d;

  always_comb begin
    d = q;
    if (!run) begin
      d.cnt  = '0;
      d.done = 1'b0;
    end else if (q.cnt >= LIM - W'(1)) begin
      d.done = 1'b1;
    end else begin
      d.cnt = q.cnt + W'(1);
    end
  end

  always_ff @(posedge core_clk) begin
    if (rst) begin
      q <= '0;
    end else begin
      q <= d;
    end
  end

  assign done = q.done;

endmodule : ssc_timer

`default_nettype wire

// *** ssc_ctrl.sv ***
// Purpose: dual-channel evaluation of a light curtain's two switching outputs,
//          restart interlock and contactor feedback monitoring
// Assumes: both curtain channels, reset button, contactor aux contacts and
//          mode selector arrive as asynchronous pins
// Notes:   locking state is left only through rst
`default_nettype none
`timescale 1ns/1ps

module ssc_ctrl #(
  parameter int unsigned DISC_CYCLES   = ssc_pkg::DISC_CYCLES,
  parameter int unsigned DROP_CYCLES   = ssc_pkg::DROP_CYCLES,
  parameter int unsigned PICKUP_CYCLES = ssc_pkg::PICKUP_CYCLES
) (
  // clock and reset
  input  wire logic             core_clk,
  input  wire logic             rst,
  // pins from curtain, operator panel and contactors
  input  wire ssc_pkg::ssc_pins_s pins,
  // contactor drives and status
  output ssc_pkg::ssc_ctl_s     ctl
);

  // ---------------------------------------------------------------
  // pin filtering
  // ---------------------------------------------------------------
  logic [ssc_pkg::PIN_W-1:0] pins_raw;
  logic [ssc_pkg::PIN_W-1:0] pins_filt;
  ssc_pkg::ssc_pins_s        f;

  assign pins_raw = pins;
  assign f        = pins_filt;

  // one vector of independent stages, one per pin
  ssc_sync #(
    .W (ssc_pkg::PIN_W)
  ) u_sync (
    .core_clk (core_clk),
    .rst      (rst),
    .pin_in   (pins_raw),
    .pin_out  (pins_filt)
  );

  // ---------------------------------------------------------------
  // per-channel view
  // ---------------------------------------------------------------
  logic ch_one_on;
  logic ch_two_on;
  logic both_on;
  logic any_off;
  logic chan_differ;
  logic fb_released;
  logic fb_any_held;

  assign ch_one_on   = f.safety_output_one;
  assign ch_two_on   = f.safety_output_two;
  assign both_on     = ch_one_on & ch_two_on;
  assign any_off     = ~ch_one_on | ~ch_two_on;
  assign chan_differ = ch_one_on ^ ch_two_on;
  assign fb_released = f.first_contactor & f.second_contactor;
  assign fb_any_held = ~f.first_contactor | ~f.second_contactor;

  // ---------------------------------------------------------------
  // timers
  // ---------------------------------------------------------------
  ssc_pkg::ssc_main_s q;
  ssc_pkg::ssc_main_s d;

  logic disc_over;
  logic drop_late;
  logic pickup_late;
  logic drop_run;
  logic pickup_run;

  assign drop_run   = (q.state == ssc_pkg::ST_DROP) & fb_any_held;
  assign pickup_run = (q.state == ssc_pkg::ST_RUN) & (f.first_contactor | f.second_contactor);

  // mismatch tolerance window
  ssc_timer #(
    .W     (ssc_pkg::TIMER_W),
    .LIMIT (DISC_CYCLES)
  ) u_disc_timer (
    .core_clk (core_clk),
    .rst      (rst),
    .run      (chan_differ),
    .done     (disc_over)
  );

  // contactors must drop out after switch-off
  ssc_timer #(
    .W     (ssc_pkg::TIMER_W),
    .LIMIT (DROP_CYCLES)
  ) u_drop_timer (
    .core_clk (core_clk),
    .rst      (rst),
    .run      (drop_run),
    .done     (drop_late)
  );

  // contactors must pick up after switch-on
  ssc_timer #(
    .W     (ssc_pkg::TIMER_W),
    .LIMIT (PICKUP_CYCLES)
  ) u_pickup_timer (
    .core_clk (core_clk),
    .rst      (rst),
    .run      (pickup_run),
    .done     (pickup_late)
  );

  // ---------------------------------------------------------------
  // events
  // ---------------------------------------------------------------
  logic btn_press;
  logic mode_changed;
  logic start_ok;

  assign btn_press    = f.reset_button & ~q.btn_prev;
  assign mode_changed = f.mode_select ^ q.mode_prev;
  // both channels on and agreeing, contactors released
  assign start_ok     = btn_press & both_on & ~chan_differ & fb_released;

  // ---------------------------------------------------------------
  // controller state machine
  // ---------------------------------------------------------------
  always_comb begin
    d           = q;
    d.btn_prev  = f.reset_button;
    d.mode_prev = f.mode_select;

    // sticky mismatch flag, set wins on every cycle
    if (disc_over) begin
      d.ctl.discrepancy = 1'b1;
    end

    case (q.state)
      ssc_pkg::ST_ARMED: begin
        if (start_ok && !mode_changed) begin
          d.state = ssc_pkg::ST_RUN;
        end
      end
      ssc_pkg::ST_RUN: begin
        if (any_off || mode_changed) begin
          d.state = ssc_pkg::ST_DROP;
        end else if (pickup_late) begin
          d.state               = ssc_pkg::ST_LOCK;
          d.ctl.contactor_fault = 1'b1;
        end
      end
      ssc_pkg::ST_DROP: begin
        if (drop_late) begin
          d.state               = ssc_pkg::ST_LOCK;
          d.ctl.contactor_fault = 1'b1;
        end else if (fb_released) begin
          d.state = ssc_pkg::ST_ARMED;
        end
      end
      ssc_pkg::ST_LOCK: begin
        d.state = ssc_pkg::ST_LOCK;
      end
      default: begin
        d.state = ssc_pkg::ST_LOCK;
      end
    endcase

    // cross-connection or short shows as lasting mismatch
    if (disc_over) begin
      d.state = ssc_pkg::ST_LOCK;
    end

    // each contactor enable built from both channels
    d.ctl.drive_first     = (d.state == ssc_pkg::ST_RUN) & ch_one_on & ch_two_on;
    d.ctl.drive_second    = (d.state == ssc_pkg::ST_RUN) & ch_two_on & ch_one_on;
    d.ctl.safe_state      = (d.state != ssc_pkg::ST_RUN);
    d.ctl.interlock_armed = (d.state == ssc_pkg::ST_ARMED);
    d.ctl.locked          = (d.state == ssc_pkg::ST_LOCK);
  end

  always_ff @(posedge core_clk) begin
    if (rst) begin
      q.state     <= ssc_pkg::ST_ARMED;
      q.btn_prev  <= 1'b1;
      q.mode_prev <= 1'b0;
      q.ctl       <= ssc_pkg::CTL_RESET;
    end else begin
      q <= d;
    end
  end

  // ---------------------------------------------------------------
  // outputs
  // ---------------------------------------------------------------
  assign ctl = q.ctl;

endmodule : ssc_ctrl

`default_nettype wire

// *** ssc_ctrl_note_unused.sv ***
`default_nettype none
`default_nettype wire

// *** ssc_checker.sv ***
// Purpose: port checker for ssc_ctrl
// Assumes: bound onto ssc_ctrl, pin to output latency five edges
// Notes:   discrepancy bound carries filter and register slack
`default_nettype none
`timescale 1ns/1ps

module ssc_checker #(
  parameter int unsigned DISC_CYCLES = 20
) (
  // clock and reset
  input wire logic               core_clk,
  input wire logic               rst,
  // watched ports
  input wire ssc_pkg::ssc_pins_s pins,
  input wire ssc_pkg::ssc_ctl_s  ctl
);
  // ---------------------------------------------------------------
  // channel mismatch counter
  // ---------------------------------------------------------------
  int unsigned diff_q;

  always_ff @(posedge core_clk) begin
    if (rst || pins.safety_output_one == pins.safety_output_two)
      diff_q <= 32'h0;
    else
      diff_q <= diff_q + 32'h1;
  end

  default clocking cb @(posedge core_clk); endclocking
  default disable iff (rst);

  // ---------------------------------------------------------------
  // properties
  // ---------------------------------------------------------------
  property p_pair; ctl.drive_first == ctl.drive_second; endproperty
  a_pair: assert property (p_pair) else $error("contactor drives differ");
  property p_ch1; (!pins.safety_output_one) [*5] |=> !ctl.drive_first; endproperty
  a_ch1: assert property (p_ch1) else $error("channel one off kept drive");
  property p_ch2; (!pins.safety_output_two) [*5] |=> !ctl.drive_second; endproperty
  a_ch2: assert property (p_ch2) else $error("channel two off kept drive");
  property p_safe; ctl.safe_state == !ctl.drive_first; endproperty
  a_safe: assert property (p_safe) else $error("safe state disagrees with drive");
  property p_btn; $rose(ctl.drive_first) |-> $past(pins.reset_button, 5); endproperty
  a_btn: assert property (p_btn) else $error("start without a press");
  property p_rel; $rose(ctl.drive_first) |-> $past(pins.first_contactor && pins.second_contactor, 5); endproperty
  a_rel: assert property (p_rel) else $error("start with a contactor held");
  property p_on; $rose(ctl.drive_first) |-> $past(pins.safety_output_one && pins.safety_output_two, 5); endproperty
  a_on: assert property (p_on) else $error("start with a channel off");
  property p_lock; ctl.locked |=> ctl.locked && !ctl.drive_first; endproperty
  a_lock: assert property (p_lock) else $error("lock released or driving");
  property p_disc; diff_q > DISC_CYCLES + 8 |-> ctl.discrepancy; endproperty
  a_disc: assert property (p_disc) else $error("mismatch not flagged");
endmodule : ssc_checker

`default_nettype wire

// *** ssc_curtain.sv ***
// Purpose: light curtain and contactor model facing ssc_ctrl
// Assumes: knobs driven by the bench
// Notes:   aux contact high = released
`default_nettype none
`timescale 1ns/1ps

module ssc_curtain (
  // curtain knobs and channels
  input  wire logic blocked,
  input  wire logic fault,
  input  wire logic short_two,
  output logic      out_one,
  output logic      out_two,
  // contactors
  input  wire logic drive_first,
  input  wire logic drive_second,
  input  wire logic stuck,
  input  wire logic no_pick,
  output logic      first_rel,
  output logic      second_rel
);
  assign out_one    = !(blocked || fault);
  assign out_two    = !(blocked || fault || short_two);
  assign first_rel  = !drive_first && !stuck;
  // no_pick: second contactor never pulls in
  assign second_rel = !drive_second || no_pick;
endmodule : ssc_curtain

`default_nettype wire

// *** test_dual_channel_safety_evaluation.sv ***
// Purpose: self-checking bench for ssc_ctrl
// Assumes: short timer parameters 20, 30, 30
// Notes:   ctl compared as {drives, safe, armed, disc, fault, lock}
`default_nettype none
`timescale 1ns/1ps

module test_dual_channel_safety_evaluation;
  logic               core_clk, rst, btn, mode, blocked, fault, short_two, stuck, no_pick;
  logic               one, two, rel_one, rel_two;
  ssc_pkg::ssc_pins_s pins;
  ssc_pkg::ssc_ctl_s  ctl;
  int                 err_count, compares;

  assign pins = {one, two, btn, rel_one, rel_two, mode};

  ssc_ctrl #(.DISC_CYCLES(20), .DROP_CYCLES(30), .PICKUP_CYCLES(30)) DUT (
    .core_clk(core_clk), .rst(rst), .pins(pins), .ctl(ctl));

  ssc_curtain u_far (.blocked(blocked), .fault(fault), .short_two(short_two), .out_one(one),
    .out_two(two), .drive_first(ctl.drive_first), .drive_second(ctl.drive_second),
    .stuck(stuck), .no_pick(no_pick), .first_rel(rel_one), .second_rel(rel_two));

  initial begin
    core_clk = 1'h0;
    forever #5 core_clk = ~core_clk;
  end

  // ---------------------------------------------------------------
  // helpers
  // ---------------------------------------------------------------
  task automatic conclude;
    $display("errors %0d compares %0d", err_count, compares);
    if (err_count == 0 && compares > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask : conclude

  task automatic chk(input logic [6:0] seen, input logic [6:0] exp);
    compares++;
    if (seen !== exp) begin
      err_count++;
      $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : chk

  task automatic idle(input int n);
    repeat (n) @(posedge core_clk);
    #1;
  endtask : idle

  task automatic press;
    @(posedge core_clk) btn <= 1'h1;
    repeat (8) @(posedge core_clk);
    btn <= 1'h0;
    idle(8);
  endtask : press

  task automatic do_reset;
    @(posedge core_clk) rst <= 1'h1;
    repeat (6) @(posedge core_clk);
    rst <= 1'h0;
    idle(6);
  endtask : do_reset

  // ---------------------------------------------------------------
  // scenarios
  // ---------------------------------------------------------------
  task automatic t_start;
    chk(ctl, 7'h18);
    press();
    chk(ctl, 7'h60);
  endtask : t_start

  task automatic t_trip;
    @(posedge core_clk) blocked <= 1'h1;
    idle(10);
    chk(ctl, 7'h18);
    @(posedge core_clk) blocked <= 1'h0;
    idle(10);
    chk(ctl, 7'h18);
    press();
    chk(ctl, 7'h60);
  endtask : t_trip

  task automatic t_refuse;
    @(posedge core_clk) fault <= 1'h1;
    idle(10);
    chk(ctl, 7'h18);
    press();
    chk(ctl, 7'h18);
    @(posedge core_clk) fault <= 1'h0;
    stuck <= 1'h1;
    press();
    chk(ctl, 7'h18);
    @(posedge core_clk) stuck <= 1'h0;
    press();
    chk(ctl, 7'h60);
  endtask : t_refuse

  task automatic t_mode;
    @(posedge core_clk) mode <= ~mode;
    idle(10);
    chk(ctl, 7'h18);
    press();
    chk(ctl, 7'h60);
  endtask : t_mode

  task automatic t_feedback;
    @(posedge core_clk) stuck <= 1'h1;
    blocked <= 1'h1;
    idle(10);
    chk(ctl, 7'h10);
    idle(40);
    chk(ctl.contactor_fault, 7'h1);
    chk(ctl.locked, 7'h1);
    @(posedge core_clk) stuck <= 1'h0;
    blocked <= 1'h0;
    press();
    chk(ctl.drive_first, 7'h0);
  endtask : t_feedback

  task automatic t_disc;
    @(posedge core_clk) short_two <= 1'h1;
    idle(10);
    chk(ctl, 7'h18);
    idle(30);
    chk(ctl.discrepancy, 7'h1);
    chk(ctl.locked, 7'h1);
  endtask : t_disc

  // second contactor never pulls in after switch-on
  task automatic t_pickup;
    @(posedge core_clk) short_two <= 1'h0;
    no_pick <= 1'h1;
    do_reset();
    press();
    chk(ctl, 7'h60);
    idle(30);
    chk(ctl, 7'h13);
  endtask : t_pickup

  initial begin
    {rst, btn, mode, blocked, fault, short_two, stuck, no_pick} = 8'h80;
    err_count = 0;
    compares = 0;
    repeat (6) @(posedge core_clk);
    rst <= 1'h0;
    idle(6);
    t_start();
    t_trip();
    t_refuse();
    t_mode();
    t_feedback();
    do_reset();
    t_start();
    t_disc();
    t_pickup();
    conclude();
  end

  initial begin
    repeat (5000) @(posedge core_clk);
    err_count++;
    conclude();
  end
endmodule : test_dual_channel_safety_evaluation

bind ssc_ctrl ssc_checker #(.DISC_CYCLES(DISC_CYCLES)) u_chk (
  .core_clk(core_clk), .rst(rst), .pins(pins), .ctl(ctl));

`default_nettype wire
